// file: bench/pcs_exec_model.sv
`timescale 1ns/1ps

module pcs_exec_model (
  // Clock.
  input wire logic core_clk,
  // Operation stream into the core.
  output pcs_pkg::pcs_op_s opReq
);
  initial opReq = '0;

  // Drives one operation at an edge and withdraws it at the edge that takes it.
  // Computed targets can cross a 256-byte block (the accumulator branch does), and the pointer is never moved under an interrupt.
  task automatic issue(input pcs_pkg::pcs_op_e code, input logic [10:0] opnd,
                       input logic [7:0] val);
    @(posedge core_clk);
    opReq <= '{1'b1, code, opnd, val, val};
    @(posedge core_clk);
    opReq.valid <= 1'b0;
  endtask : issue

  task automatic idle;
    @(posedge core_clk);
    opReq.valid <= 1'b0;
  endtask : idle
endmodule : pcs_exec_model

// file: bench/test_program_counter_and_return_stack.sv
`timescale 1ns/1ps
`include "pcs_regs.svh"

module test_program_counter_and_return_stack;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic cke = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [14:0] pcAddr;
  logic faultPulse;
  logic ovfFlag;
  logic unfFlag;
  pcs_pkg::pcs_op_s opReq;
  int failures = 0;
  int n_checks = 0;
  int pulses = 0;
  logic [31:0] rdVal;

  always #12.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (faultPulse === 1'b1) pulses <= pulses + 1;
  end

  pcs_exec_model exec (.core_clk(core_clk), .opReq(opReq));

  pcs_core dut (.core_clk(core_clk), .resetn(resetn), .cke(cke), .opReq(opReq),
    .pcAddr(pcAddr), .stackFaultReset(faultPulse), .stackOverflowFlag(ovfFlag),
    .stackUnderflowFlag(unfFlag), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));

  task automatic complete_run;
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chkPc(input logic [14:0] exp);
    #1;
    chk("pc", {17'h0, exp}, {17'h0, pcAddr});
  endtask : chkPc

  // Waits for a rising edge that samples ready high; read data is taken at that edge.
  task automatic waitReady(output logic [31:0] data);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) chk("ready", 32'h1, 32'h0);
    data = hrdata;
  endtask : waitReady

  task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wdata);
    logic [31:0] dummy;
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    waitReady(dummy);
    htrans <= 2'h0;
    hwdata <= wdata;
    waitReady(rdVal);
  endtask : bus

  task automatic wr(input logic [11:0] idx, input logic [31:0] data);
    bus(1'b1, idx, data);
  endtask : wr

  task automatic rdchk(input string name, input logic [11:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(name, exp, rdVal);
  endtask : rdchk

  task automatic step(input pcs_pkg::pcs_op_e code, input logic [10:0] opnd,
                      input logic [7:0] val, input logic [14:0] expPc);
    exec.issue(code, opnd, val);
    chkPc(expPc);
  endtask : step

  initial begin
    #200000;
    chk("watchdog", 32'h1, 32'h0);
    complete_run();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    chkPc(15'h0000);
    rdchk("ptr", `PCS_IDX_RET_PTR, 32'h1f);
    wr(`PCS_IDX_PC_LATCH, 32'h55);
    wr(`PCS_IDX_PC_LOW, 32'h34);
    chkPc(15'h5534);
    rdchk("status", `PCS_IDX_STATUS, {1'b0, 15'h5534, 16'h0});
    step(pcs_pkg::OP_PC_LOW_WRITE, 11'h0, 8'h12, 15'h5512);
    step(pcs_pkg::OP_CALL, 11'h7ab, 8'h0, 15'h57ab);
    step(pcs_pkg::OP_CALL_ACC, 11'h0, 8'h9c, 15'h559c);
    step(pcs_pkg::OP_BRANCH_ACC, 11'h0, 8'hff, 15'h569c);
    step(pcs_pkg::OP_REL_JUMP, 11'h1f0, 8'h0, 15'h568d);
    exec.idle();
    rdchk("ptr", `PCS_IDX_RET_PTR, 32'h01);
    rdchk("toplow", `PCS_IDX_TOP_LOW, 32'hac);
    rdchk("tophigh", `PCS_IDX_TOP_HIGH, 32'h57);
    rdchk("latch", `PCS_IDX_PC_LATCH, 32'h55);
    step(pcs_pkg::OP_RETURN, 11'h0, 8'h0, 15'h57ac);
    step(pcs_pkg::OP_RETURN_LIT, 11'h0, 8'h0, 15'h5513);
    step(pcs_pkg::OP_INT_VECTOR, 11'h004, 8'h0, 15'h0004);
    exec.idle();
    rdchk("toplow", `PCS_IDX_TOP_LOW, 32'h13);
    step(pcs_pkg::OP_RETURN_INT, 11'h0, 8'h0, 15'h5513);
    exec.idle();
    rdchk("ptr", `PCS_IDX_RET_PTR, 32'h1f);
    for (int i = 0; i < 17; i++) begin
      step(pcs_pkg::OP_CALL, 11'(i), 8'h0, 15'(15'h5000 + i));
    end
    exec.idle();
    rdchk("ptr", `PCS_IDX_RET_PTR, 32'h10);
    rdchk("status", `PCS_IDX_STATUS, {1'b0, 15'h5010, 16'h1});
    chk("ovf", 32'h1, {31'h0, ovfFlag});
    wr(`PCS_IDX_RET_PTR, 32'h00);
    rdchk("toplow", `PCS_IDX_TOP_LOW, 32'h10);
    rdchk("tophigh", `PCS_IDX_TOP_HIGH, 32'h50);
    wr(`PCS_IDX_STATUS, 32'h3);
    wr(`PCS_IDX_RET_PTR, 32'h1f);
    step(pcs_pkg::OP_RETURN, 11'h0, 8'h0, 15'h500f);
    exec.idle();
    rdchk("ptr", `PCS_IDX_RET_PTR, 32'h1e);
    rdchk("status", `PCS_IDX_STATUS, {1'b0, 15'h500f, 16'h2});
    chk("unf", 32'h1, {31'h0, unfFlag});
    wr(`PCS_IDX_STATUS, 32'h3);
    wr(`PCS_IDX_CTRL, 32'h1);
    wr(`PCS_IDX_RET_PTR, 32'h0f);
    exec.issue(pcs_pkg::OP_CALL, 11'h0, 8'h0);
    exec.idle();
    rdchk("ptr", `PCS_IDX_RET_PTR, 32'h1f);
    chkPc(15'h0000);
    chk("pulses", 32'h1, 32'(pulses));
    rdchk("status", `PCS_IDX_STATUS, 32'h1);
    wr(`PCS_IDX_CTRL, 32'h0);
    wr(`PCS_IDX_RET_PTR, 32'h03);
    wr(`PCS_IDX_TOP_LOW, 32'ha5);
    wr(`PCS_IDX_TOP_HIGH, 32'h2b);
    rdchk("toplow", `PCS_IDX_TOP_LOW, 32'ha5);
    rdchk("tophigh", `PCS_IDX_TOP_HIGH, 32'h2b);
    chk("hresp", 32'h0, {31'h0, hresp});
    step(pcs_pkg::OP_STEP, 11'h0, 8'h0, 15'h0001);
    @(posedge core_clk);
    cke <= 1'b0;
    step(pcs_pkg::OP_STEP, 11'h0, 8'h0, 15'h0001);
    @(posedge core_clk);
    cke <= 1'b1;
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    chkPc(15'h0000);
    rdchk("ptr", `PCS_IDX_RET_PTR, 32'h1f);
    rdchk("unmapped", 12'h0ab, 32'h0);
    complete_run();
  end
endmodule : test_program_counter_and_return_stack

// file: hw/pcs_core.sv
// How it works
// RULE1 - 15-bit PC, low byte register, high from latch
// RULE2 - Any reset clears the whole PC
// RULE3 - Low byte write loads high bits from latch
// RULE4 - Software minds tables crossing 256-byte blocks
// RULE5 - Call: operand gives 11 bits, latch bits 6:3
// RULE6 - Call via accumulator: latch plus accumulator, push
// RULE7 - Branch: next address plus unsigned accumulator
// RULE8 - Relative jump: next address plus signed operand
// RULE9 - Sixteen 15-bit entries, outside memory spaces
// RULE10 - Calls and interrupts push, returns pop
// RULE11 - Push and pop leave the latch alone
// RULE12 - Fault reset off: stack wraps circularly
// RULE13 - Overflow and underflow always set their flags
// RULE14 - Top registers access entry chosen by pointer
// RULE15 - Stack pointer is five bits wide
// RULE16 - Push increments then stores; pop loads then decrements
// RULE17 - Empty stack pointer is 0x1F
// RULE18 - Fault reset on: overflow or underflow resets
// RULE19 - Software minds pointer writes with interrupts enabled
// RULE20 - Pointer counts modulo 32; faults from transitions
`timescale 1ns/1ps
`include "pcs_regs.svh"

module pcs_core #(
  parameter int PC_WIDTH = 15,
  parameter int STACK_DEPTH = 16
) (
  // Clock, reset and enable.
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cke,
  // Instruction execution side.
  input wire pcs_pkg::pcs_op_s opReq,
  output logic [14:0] pcAddr,
  output logic stackFaultReset,
  output logic stackOverflowFlag,
  output logic stackUnderflowFlag,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  if (PC_WIDTH != 15 || STACK_DEPTH != 16) begin : g_check
    $error("pcs_core supports only a 15-bit PC and a 16-entry stack");
  end

  pcs_pkg::pcs_state_s stateQ;
  pcs_pkg::pcs_state_s stateD;

  logic [14:0] nextPc;
  logic isPush;
  logic isPop;
  logic ovfEv;
  logic unfEv;
  logic faultEv;
  logic addrPhase;
  logic [11:0] busIdx;
  logic busMapped;

  assign nextPc = stateQ.pc + 15'h0001;
  // RULE10
  assign isPush = opReq.valid && (opReq.code == pcs_pkg::OP_CALL ||
                  opReq.code == pcs_pkg::OP_CALL_ACC || opReq.code == pcs_pkg::OP_INT_VECTOR);
  assign isPop = opReq.valid && (opReq.code == pcs_pkg::OP_RETURN ||
                 opReq.code == pcs_pkg::OP_RETURN_LIT || opReq.code == pcs_pkg::OP_RETURN_INT);
  // RULE20
  assign ovfEv = isPush && stateQ.ptr == `PCS_PTR_LAST;
  assign unfEv = isPop && stateQ.ptr == `PCS_PTR_EMPTY;
  assign faultEv = stateQ.faultRstEn && (ovfEv || unfEv);
  assign addrPhase = hsel && htrans[1] && hready;
  assign busIdx = haddr[13:2];
  assign busMapped = haddr[31:14] == 18'h00000 && haddr[1:0] == 2'h0;

  always_comb begin
    stateD = stateQ;
    stateD.faultPulse = 1'b0;
    stateD.wrPend = 1'b0;

    // Write data phase. Software effects go first so that core events win.
    if (stateQ.wrPend) begin
      case (stateQ.wrIdx)
        `PCS_IDX_RET_PTR: begin
          stateD.ptr = hwdata[4:0]; // RULE15
        end
        `PCS_IDX_TOP_LOW: begin
          stateD.stack[stateD.ptr[3:0]][7:0] = hwdata[7:0]; // RULE14
        end
        `PCS_IDX_TOP_HIGH: begin
          stateD.stack[stateD.ptr[3:0]][14:8] = hwdata[6:0]; // RULE14
        end
        `PCS_IDX_PC_LOW: begin
          stateD.pc = {stateQ.latch, hwdata[7:0]}; // RULE3
        end
        `PCS_IDX_PC_LATCH: begin
          stateD.latch = hwdata[6:0];
        end
        `PCS_IDX_CTRL: begin
          stateD.faultRstEn = hwdata[`PCS_CTRL_FAULT_RST_BIT];
        end
        `PCS_IDX_STATUS: begin
          stateD.ovf = stateQ.ovf & ~hwdata[`PCS_STAT_OVF_BIT];
          stateD.unf = stateQ.unf & ~hwdata[`PCS_STAT_UNF_BIT];
        end
        default: begin
        end
      endcase
    end

    // Core operation; the latch is never touched here.
    if (opReq.valid) begin
      case (opReq.code)
        pcs_pkg::OP_STEP: begin
          stateD.pc = nextPc;
        end
        pcs_pkg::OP_PC_LOW_WRITE: begin
          stateD.pc = {stateQ.latch, opReq.pcLowData}; // RULE1 RULE3
        end
        pcs_pkg::OP_CALL: begin
          stateD.pc = {stateQ.latch[6:3], opReq.operand}; // RULE5
        end
        pcs_pkg::OP_CALL_ACC: begin
          stateD.pc = {stateQ.latch, opReq.accum}; // RULE6
        end
        pcs_pkg::OP_BRANCH_ACC: begin
          stateD.pc = nextPc + {7'h00, opReq.accum}; // RULE7
        end
        pcs_pkg::OP_REL_JUMP: begin
          stateD.pc = nextPc + {{6{opReq.operand[8]}}, opReq.operand[8:0]}; // RULE8
        end
        pcs_pkg::OP_RETURN, pcs_pkg::OP_RETURN_LIT, pcs_pkg::OP_RETURN_INT: begin
          stateD.pc = stateQ.stack[stateQ.ptr[3:0]]; // RULE16
        end
        pcs_pkg::OP_INT_VECTOR: begin
          stateD.pc = {4'h0, opReq.operand};
        end
        default: begin
        end
      endcase
    end

    // Push stores after increment; the interrupt saves the address it preempted.
    if (isPush) begin // RULE11
      stateD.ptr = stateQ.ptr + `PCS_PTR_STEP; // RULE16 RULE20
      // RULE9 RULE12
      stateD.stack[stateD.ptr[3:0]] = (opReq.code == pcs_pkg::OP_INT_VECTOR) ?
                                      stateQ.pc : nextPc;
    end
    if (isPop) begin
      stateD.ptr = stateQ.ptr - `PCS_PTR_STEP; // RULE16 RULE17
    end

    // RULE13
    if (ovfEv) begin
      stateD.ovf = 1'b1;
    end
    if (unfEv) begin
      stateD.unf = 1'b1;
    end

    // RULE18
    if (faultEv) begin
      stateD.pc = `PCS_RST_PC;
      stateD.latch = `PCS_RST_LATCH;
      stateD.ptr = `PCS_PTR_EMPTY;
      stateD.faultPulse = 1'b1;
    end

    // Read data phase: one wait state, so a write just before is seen.
    if (stateQ.rdPend) begin
      stateD.rdPend = 1'b0;
      stateD.hready = 1'b1;
      stateD.hrdata = 32'h00000000;
      case (stateQ.rdIdx)
        `PCS_IDX_RET_PTR: begin
          stateD.hrdata[4:0] = stateQ.ptr;
        end
        `PCS_IDX_TOP_LOW: begin
          stateD.hrdata[7:0] = stateQ.stack[stateQ.ptr[3:0]][7:0]; // RULE14
        end
        `PCS_IDX_TOP_HIGH: begin
          stateD.hrdata[6:0] = stateQ.stack[stateQ.ptr[3:0]][14:8]; // RULE14
        end
        `PCS_IDX_PC_LOW: begin
          stateD.hrdata[7:0] = stateQ.pc[7:0]; // RULE1
        end
        `PCS_IDX_PC_LATCH: begin
          stateD.hrdata[6:0] = stateQ.latch;
        end
        `PCS_IDX_CTRL: begin
          stateD.hrdata[`PCS_CTRL_FAULT_RST_BIT] = stateQ.faultRstEn;
        end
        `PCS_IDX_STATUS: begin
          stateD.hrdata[`PCS_STAT_OVF_BIT] = stateQ.ovf;
          stateD.hrdata[`PCS_STAT_UNF_BIT] = stateQ.unf;
          stateD.hrdata[`PCS_STAT_PC_MSB:`PCS_STAT_PC_LSB] = stateQ.pc;
        end
        default: begin
        end
      endcase
    end

    // Address phase; unmapped addresses read zero and ignore writes.
    if (addrPhase) begin
      if (hwrite) begin
        stateD.wrPend = busMapped;
        stateD.wrIdx = busIdx;
      end else begin
        stateD.rdPend = 1'b1;
        stateD.hready = 1'b0;
        stateD.rdIdx = busMapped ? busIdx : 12'h000;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stateQ <= '{ptr: `PCS_PTR_EMPTY, pc: `PCS_RST_PC, hready: 1'b1, default: '0}; // RULE2 RULE17
    end else if (cke) begin
      stateQ <= stateD;
    end
  end

  assign pcAddr = stateQ.pc;
  assign stackFaultReset = stateQ.faultPulse;
  assign stackOverflowFlag = stateQ.ovf;
  assign stackUnderflowFlag = stateQ.unf;
  assign hreadyout = stateQ.hready;
  assign hresp = 1'b0;
  assign hrdata = stateQ.hrdata;

  // Checks.
  logic plainOp;
  assign plainOp = cke && opReq.valid && !stateQ.wrPend && !faultEv;

  sequence s_push_empty;
    plainOp && isPush && stateQ.ptr == `PCS_PTR_EMPTY;
  endsequence

  sequence s_pop_zero;
    plainOp && isPop && stateQ.ptr == 5'h00;
  endsequence

  property p_reset_pc;
    @(posedge core_clk) !resetn |=> pcAddr == 15'h0000 && stateQ.ptr == `PCS_PTR_EMPTY;
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("reset left PC or pointer set"); // RULE2

  property p_pc_low_write;
    @(posedge core_clk) disable iff (!resetn)
      plainOp && opReq.code == pcs_pkg::OP_PC_LOW_WRITE |=>
      pcAddr == {$past(stateQ.latch), $past(opReq.pcLowData)};
  endproperty
  a_pc_low_write: assert property (p_pc_low_write) else $error("low byte write bad PC"); // RULE3

  property p_call;
    @(posedge core_clk) disable iff (!resetn)
      plainOp && opReq.code == pcs_pkg::OP_CALL |=>
      pcAddr == {$past(stateQ.latch[6:3]), $past(opReq.operand)} &&
      stateQ.stack[stateQ.ptr[3:0]] == $past(stateQ.pc) + 15'h0001;
  endproperty
  a_call: assert property (p_call) else $error("call target or return address wrong"); // RULE5

  property p_call_acc;
    @(posedge core_clk) disable iff (!resetn)
      plainOp && opReq.code == pcs_pkg::OP_CALL_ACC |=>
      pcAddr == {$past(stateQ.latch), $past(opReq.accum)} &&
      stateQ.ptr == $past(stateQ.ptr) + 5'h01;
  endproperty
  a_call_acc: assert property (p_call_acc) else $error("accumulator call wrong"); // RULE6

  property p_branch_acc;
    @(posedge core_clk) disable iff (!resetn)
      plainOp && opReq.code == pcs_pkg::OP_BRANCH_ACC |=>
      pcAddr == $past(stateQ.pc) + 15'h0001 + {7'h00, $past(opReq.accum)};
  endproperty
  a_branch_acc: assert property (p_branch_acc) else $error("accumulator branch wrong"); // RULE7

  property p_rel_jump;
    @(posedge core_clk) disable iff (!resetn)
      plainOp && opReq.code == pcs_pkg::OP_REL_JUMP |=>
      pcAddr == $past(stateQ.pc) + 15'h0001 +
      {{6{$past(opReq.operand[8])}}, $past(opReq.operand[8:0])};
  endproperty
  a_rel_jump: assert property (p_rel_jump) else $error("relative jump wrong"); // RULE8

  property p_latch_kept;
    @(posedge core_clk) disable iff (!resetn)
      plainOp && (isPush || isPop) |=> stateQ.latch == $past(stateQ.latch);
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("latch changed by stack"); // RULE11

  property p_push_empty;
    @(posedge core_clk) disable iff (!resetn)
      s_push_empty |=> stateQ.ptr == 5'h00;
  endproperty
  a_push_empty: assert property (p_push_empty) else $error("push from empty wrong"); // RULE17

  property p_pop_zero;
    @(posedge core_clk) disable iff (!resetn)
      s_pop_zero |=> stateQ.ptr == `PCS_PTR_EMPTY && pcAddr == $past(stateQ.stack[0]);
  endproperty
  a_pop_zero: assert property (p_pop_zero) else $error("return to empty wrong"); // RULE17

  property p_wrap;
    @(posedge core_clk) disable iff (!resetn)
      cke && !stateQ.faultRstEn && ovfEv && !stateQ.wrPend |=>
      stateQ.ptr == 5'h10 && stackOverflowFlag && !stackFaultReset;
  endproperty
  a_wrap: assert property (p_wrap) else $error("circular overflow wrong"); // RULE12

  property p_fault;
    @(posedge core_clk) disable iff (!resetn)
      cke && stateQ.faultRstEn && (ovfEv || unfEv) |=>
      stackFaultReset && pcAddr == 15'h0000 && stateQ.ptr == `PCS_PTR_EMPTY &&
      (stackOverflowFlag || stackUnderflowFlag) ##1
      (!$past(cke) || $past(faultEv) || !stackFaultReset);
  endproperty
  a_fault: assert property (p_fault) else $error("fault reset wrong"); // RULE18

  property p_underflow_flag;
    @(posedge core_clk) disable iff (!resetn)
      cke && unfEv |=> stackUnderflowFlag;
  endproperty
  a_underflow_flag: assert property (p_underflow_flag) else $error("underflow flag missed"); // RULE13

  property p_overflow_flag;
    @(posedge core_clk) disable iff (!resetn)
      cke && ovfEv |=> stackOverflowFlag;
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag missed"); // RULE13

  property p_return;
    @(posedge core_clk) disable iff (!resetn)
      plainOp && isPop |=> pcAddr == $past(stateQ.stack[stateQ.ptr[3:0]]) &&
      stateQ.ptr == $past(stateQ.ptr) - 5'h01;
  endproperty
  a_return: assert property (p_return) else $error("return load or decrement wrong"); // RULE16

  property p_int_push;
    @(posedge core_clk) disable iff (!resetn)
      plainOp && opReq.code == pcs_pkg::OP_INT_VECTOR |=>
      stateQ.stack[stateQ.ptr[3:0]] == $past(stateQ.pc) && pcAddr == {4'h0, $past(opReq.operand)};
  endproperty
  a_int_push: assert property (p_int_push) else $error("interrupt push wrong"); // RULE10

  property p_ptr_write;
    @(posedge core_clk) disable iff (!resetn)
      cke && stateQ.wrPend && stateQ.wrIdx == `PCS_IDX_RET_PTR && !isPush && !isPop |=>
      stateQ.ptr == $past(hwdata[4:0]);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost"); // RULE15

  property p_top_read;
    @(posedge core_clk) disable iff (!resetn)
      cke && stateQ.rdPend && stateQ.rdIdx == `PCS_IDX_TOP_HIGH |=>
      hreadyout && hrdata == {25'h0, $past(stateQ.stack[stateQ.ptr[3:0]][14:8])};
  endproperty
  a_top_read: assert property (p_top_read) else $error("top high read wrong"); // RULE14

  property p_pc_low_bus;
    @(posedge core_clk) disable iff (!resetn)
      cke && stateQ.wrPend && stateQ.wrIdx == `PCS_IDX_PC_LOW && !opReq.valid |=>
      pcAddr == {$past(stateQ.latch), $past(hwdata[7:0])};
  endproperty
  a_pc_low_bus: assert property (p_pc_low_bus) else $error("bus low byte write bad PC"); // RULE3

  property p_read_wait;
    @(posedge core_clk) disable iff (!resetn)
      cke && addrPhase && !hwrite |=> !hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state missing"); // RULE14

  property p_freeze;
    @(posedge core_clk) disable iff (!resetn)
      !cke |=> $stable(stateQ);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled"); // RULE1

endmodule : pcs_core

// file: hw/pcs_pkg.sv
package pcs_pkg;

  typedef enum logic [3:0] {
    OP_STEP,
    OP_PC_LOW_WRITE,
    OP_CALL,
    OP_CALL_ACC,
    OP_BRANCH_ACC,
    OP_REL_JUMP,
    OP_RETURN,
    OP_RETURN_LIT,
    OP_RETURN_INT,
    OP_INT_VECTOR
  } pcs_op_e;

  typedef struct packed {
    logic valid;
    pcs_op_e code;
    logic [10:0] operand;
    logic [7:0] accum;
    logic [7:0] pcLowData;
  } pcs_op_s;

  typedef struct packed {
    logic [14:0] pc;
    logic [6:0] latch;
    logic [4:0] ptr;
    logic [15:0][14:0] stack;
    logic faultRstEn;
    logic ovf;
    logic unf;
    logic faultPulse;
    logic rdPend;
    logic [11:0] rdIdx;
    logic wrPend;
    logic [11:0] wrIdx;
    logic [31:0] hrdata;
    logic hready;
  } pcs_state_s;

endpackage : pcs_pkg

// file: hw/pcs_regs.svh
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// Register indices; the byte address is four times the index.
`define PCS_IDX_RET_PTR 12'hfed
`define PCS_IDX_TOP_LOW 12'hfee
`define PCS_IDX_TOP_HIGH 12'hfef
`define PCS_IDX_PC_LOW 12'hf00
`define PCS_IDX_PC_LATCH 12'hf01
`define PCS_IDX_CTRL 12'hf02
`define PCS_IDX_STATUS 12'hf03

// Stack pointer values.
`define PCS_PTR_EMPTY 5'h1f
`define PCS_PTR_LAST 5'h0f
`define PCS_PTR_STEP 5'h01

// Reset values.
`define PCS_RST_PC 15'h0000
`define PCS_RST_LATCH 7'h00

// Field positions.
`define PCS_CTRL_FAULT_RST_BIT 0
`define PCS_STAT_OVF_BIT 0
`define PCS_STAT_UNF_BIT 1
`define PCS_STAT_PC_LSB 16
`define PCS_STAT_PC_MSB 30

`endif
